// File: rtl/ipc_config_regs.sv
`timescale 1ns/1ps
module ipc_config_regs
  import ipc_pkg::*;
#(
  parameter logic [2:0] MAX_PAYLOAD_CAP = 3'h0,
  parameter logic EP_FLR_CAP = 1'b1,
  parameter logic EP_NEEDS_ARI = 1'b0,
  parameter logic EP_PEER_ATOMICS = 1'b0,
  parameter logic EP_ATOMIC_32_64 = 1'b0,
  parameter logic EP_ATOMIC_CAS128 = 1'b0,
  parameter logic EP_FRS_MSGS = 1'b0,
  parameter logic EP_LTR_SUP = 1'b0,
  parameter logic [1:0] EP_OBFF_SUP = 2'h0,
  parameter logic EP_E2E_PREFIX_SUP = 1'b0,
  parameter logic [1:0] EP_E2E_PREFIX_MAX = 2'h0,
  parameter logic EP_CAN_MARK_RO = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dll_state_changed,
  input wire logic presence_detect,
  input wire logic ep_mem_req_in,
  output logic ep_mem_req_out,
  output logic ep_hot_reset,
  output logic ep_relaxed_order_en,
  output logic ep_no_snoop_en,
  output logic ep_flr_pulse
);

  // Fixed capability images
  localparam logic [31:0] DEV_CAPS_VAL = IPC_DEV_CAPS_FIXED
    | {29'h0, MAX_PAYLOAD_CAP};
  localparam logic [31:0] EP_DEV_CAPS2_VAL = IPC_DEV_CAPS2_FIXED // RULE22
    | {8'h0, EP_E2E_PREFIX_MAX, EP_E2E_PREFIX_SUP, 1'b0, 8'h0,
       EP_LTR_SUP, 11'h0}
    | {12'h0, EP_OBFF_SUP, 18'h0};
  localparam logic [31:0] RP_DEV_CAPS2_VAL = EP_DEV_CAPS2_VAL // RULE20 RULE21
    | {EP_FRS_MSGS, 21'h0, EP_ATOMIC_CAS128, EP_ATOMIC_32_64,
       EP_ATOMIC_32_64, EP_PEER_ATOMICS, EP_NEEDS_ARI, 5'h0};
  localparam logic [31:0] EP_DCTL_MASK = EP_CAN_MARK_RO
    ? IPC_DCTL_EP_MASK : (IPC_DCTL_EP_MASK & 32'hFFFF_FFEF);

  logic [31:0] cmd_reg;
  logic [31:0] brg_reg;
  logic [31:0] pmcs_reg;
  logic [31:0] slot_reg;
  logic [31:0] rp_dctl_reg;
  logic [31:0] ep_dctl_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic mem_req_reg;
  logic hot_reset_reg;
  logic ro_en_reg;
  logic ns_en_reg;
  logic flr_reg;
  logic [31:0] rd_next;
  logic hit_next;
  logic wr_en;
  logic [31:0] wmask;

  // Access phase write strobe and byte lane mask
  assign wr_en = psel & penable & pwrite & pready_reg;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                  {8{pstrb[0]}}};

  // Read decode; constant and unimplemented fields read fixed values
  always_comb begin
    rd_next = IPC_RESET_VAL;
    hit_next = 1'b1;
    unique case (paddr)
      IPC_OFF_RP_COMMAND: rd_next = cmd_reg;
      IPC_OFF_RP_BRIDGE_CTL: rd_next = brg_reg;
      IPC_OFF_PM_CAPS: rd_next = IPC_PM_CAPS_VAL; // RULE4
      IPC_OFF_PM_CTL_STAT: rd_next = pmcs_reg | IPC_PMCS_CONST; // RULE5
      IPC_OFF_PM_DATA: rd_next = IPC_RESET_VAL; // RULE6
      IPC_OFF_SLOT_CAPS: rd_next = IPC_RESET_VAL; // RULE7
      IPC_OFF_SLOT_CTL_STAT: rd_next = slot_reg; // RULE8 RULE9
      IPC_OFF_RP_EXP_CAPS: rd_next = IPC_RP_EXP_CAPS_VAL; // RULE10
      IPC_OFF_EP_EXP_CAPS: rd_next = IPC_EP_EXP_CAPS_VAL; // RULE10
      IPC_OFF_DEV_CAPS: rd_next = DEV_CAPS_VAL; // RULE11 RULE12 RULE13
      IPC_OFF_RP_DEV_CTL: rd_next = rp_dctl_reg; // RULE14 RULE18
      IPC_OFF_EP_DEV_CTL: rd_next = ep_dctl_reg; // RULE14
      IPC_OFF_RP_DEV_CAPS2: rd_next = RP_DEV_CAPS2_VAL; // RULE19 RULE20
      IPC_OFF_EP_DEV_CAPS2: rd_next = EP_DEV_CAPS2_VAL; // RULE23 RULE24
      default: hit_next = 1'b0;
    endcase
  end

  // APB answer: one wait-free access phase after each setup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= IPC_RESET_VAL;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? IPC_RESET_VAL : rd_next;
      pready_reg <= 1'b1;
      pslverr_reg <= ~hit_next;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Command and bridge control of the root port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= IPC_RESET_VAL;
      brg_reg <= IPC_RESET_VAL;
    end else if (wr_en && paddr == IPC_OFF_RP_COMMAND) begin
      cmd_reg[IPC_CMD_BUS_MASTER_BIT] <= (pwdata[IPC_CMD_BUS_MASTER_BIT]
        & wmask[IPC_CMD_BUS_MASTER_BIT]) | (cmd_reg[IPC_CMD_BUS_MASTER_BIT]
        & ~wmask[IPC_CMD_BUS_MASTER_BIT]);
    end else if (wr_en && paddr == IPC_OFF_RP_BRIDGE_CTL) begin
      brg_reg[IPC_BRG_SBR_BIT] <= (pwdata[IPC_BRG_SBR_BIT]
        & wmask[IPC_BRG_SBR_BIT]) | (brg_reg[IPC_BRG_SBR_BIT]
        & ~wmask[IPC_BRG_SBR_BIT]);
    end
  end

  // Power state only; data select and scale stay zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmcs_reg <= IPC_RESET_VAL;
    end else if (wr_en && paddr == IPC_OFF_PM_CTL_STAT) begin
      pmcs_reg <= (pwdata & wmask & IPC_PMCS_MASK) // RULE5 RULE25
        | (pmcs_reg & ~(wmask & IPC_PMCS_MASK));
    end
  end

  // Slot control/status: enable bit, sticky change flag, presence
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= IPC_RESET_VAL;
    end else begin
      slot_reg[IPC_SLOT_PDS_BIT] <= presence_detect; // RULE9
      if (wr_en && paddr == IPC_OFF_SLOT_CTL_STAT) begin
        if (wmask[IPC_SLOT_DLLSC_EN_BIT]) begin
          slot_reg[IPC_SLOT_DLLSC_EN_BIT] <=
            pwdata[IPC_SLOT_DLLSC_EN_BIT]; // RULE8
        end
      end
      // Hardware set wins over a write-one clear
      if (dll_state_changed) begin
        slot_reg[IPC_SLOT_DLLSC_BIT] <= 1'b1; // RULE9
      end else if (wr_en && paddr == IPC_OFF_SLOT_CTL_STAT
                   && wmask[IPC_SLOT_DLLSC_BIT]
                   && pwdata[IPC_SLOT_DLLSC_BIT]) begin
        slot_reg[IPC_SLOT_DLLSC_BIT] <= 1'b0;
      end
    end
  end

  // Device control of both functions; ignored fields just store
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_dctl_reg <= IPC_RESET_VAL;
      ep_dctl_reg <= IPC_RESET_VAL;
    end else if (wr_en && paddr == IPC_OFF_RP_DEV_CTL) begin
      rp_dctl_reg <= (pwdata & wmask & IPC_DCTL_RP_MASK) // RULE15 RULE18
        | (rp_dctl_reg & ~(wmask & IPC_DCTL_RP_MASK));
    end else if (wr_en && paddr == IPC_OFF_EP_DEV_CTL) begin
      ep_dctl_reg <= (pwdata & wmask & EP_DCTL_MASK) // RULE14 RULE15
        | (ep_dctl_reg & ~(wmask & EP_DCTL_MASK));
    end
  end

  // Endpoint controls; root port relaxed order and no snoop unused
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_reg <= 1'b0;
      hot_reset_reg <= 1'b0;
      ro_en_reg <= 1'b0;
      ns_en_reg <= 1'b0;
      flr_reg <= 1'b0;
    end else begin
      mem_req_reg <= ep_mem_req_in & cmd_reg[IPC_CMD_BUS_MASTER_BIT]; // RULE3
      hot_reset_reg <= brg_reg[IPC_BRG_SBR_BIT]; // RULE2
      ro_en_reg <= ep_dctl_reg[IPC_DCTL_RO_BIT]; // RULE16
      ns_en_reg <= ep_dctl_reg[IPC_DCTL_NS_BIT]; // RULE17 RULE1
      flr_reg <= EP_FLR_CAP & wr_en && paddr == IPC_OFF_EP_DEV_CTL
        && wmask[IPC_DCTL_FLR_BIT] && pwdata[IPC_DCTL_FLR_BIT];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ep_mem_req_out = mem_req_reg;
  assign ep_hot_reset = hot_reset_reg;
  assign ep_relaxed_order_en = ro_en_reg;
  assign ep_no_snoop_en = ns_en_reg;
  assign ep_flr_pulse = flr_reg;

  // Read answer helper
  logic rd_done;
  assign rd_done = psel & penable & pready_reg & ~pwrite;

  property p_hot_reset;
    @(posedge core_clk) disable iff (!rst_n)
    wr_en && paddr == IPC_OFF_RP_BRIDGE_CTL && pstrb[0]
      && pwdata[IPC_BRG_SBR_BIT] |=> ##1 ep_hot_reset;
  endproperty
  a_hot_reset: assert property (p_hot_reset) // RULE2
    else $error("hot reset not applied after bus reset set");

  property p_bus_master_gate;
    @(posedge core_clk) disable iff (!rst_n)
    ep_mem_req_out |-> $past(cmd_reg[IPC_CMD_BUS_MASTER_BIT])
      && $past(ep_mem_req_in);
  endproperty
  a_bus_master_gate: assert property (p_bus_master_gate) // RULE3
    else $error("memory request passed with bus master off");

  property p_pm_caps;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_PM_CAPS |-> prdata[8:6] == 3'h0;
  endproperty
  a_pm_caps: assert property (p_pm_caps) // RULE4
    else $error("aux current not zero");

  property p_slot_caps;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && (paddr == IPC_OFF_SLOT_CAPS || paddr == IPC_OFF_PM_DATA)
      |-> prdata == 32'h0000_0000;
  endproperty
  a_slot_caps: assert property (p_slot_caps) // RULE7 RULE6
    else $error("slot capabilities or pm data not zero");

  property p_slot_bits;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_SLOT_CTL_STAT
      |-> (prdata & 32'hFEBF_EFFF) == 32'h0000_0000;
  endproperty
  a_slot_bits: assert property (p_slot_bits) // RULE8 RULE9
    else $error("unused slot control or status bit set");

  property p_dllsc_set;
    @(posedge core_clk) disable iff (!rst_n)
    dll_state_changed |=> slot_reg[IPC_SLOT_DLLSC_BIT] [*1];
  endproperty
  a_dllsc_set: assert property (p_dllsc_set) // RULE9
    else $error("link state change lost");

  property p_rp_flr;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_RP_DEV_CTL
      |-> !prdata[IPC_DCTL_FLR_BIT] && prdata[10:9] == 2'h0;
  endproperty
  a_rp_flr: assert property (p_rp_flr) // RULE18
    else $error("root port function reset or phantom bit set");

  property p_ro_follow;
    @(posedge core_clk) disable iff (!rst_n)
    wr_en && paddr == IPC_OFF_EP_DEV_CTL && pstrb[0]
      |=> ##1 ep_relaxed_order_en == (EP_CAN_MARK_RO
        && $past(pwdata[IPC_DCTL_RO_BIT], 2));
  endproperty
  a_ro_follow: assert property (p_ro_follow) // RULE16
    else $error("relaxed order enable not followed");

  property p_rp_ignored;
    @(posedge core_clk) disable iff (!rst_n)
    wr_en && paddr == IPC_OFF_RP_DEV_CTL |=> ##1
      $stable(ep_no_snoop_en) && $stable(ep_relaxed_order_en);
  endproperty
  a_rp_ignored: assert property (p_rp_ignored) // RULE17 RULE1
    else $error("root port device control changed endpoint");

  property p_const_read;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_RP_DEV_CAPS2
      |-> prdata[4:0] == 5'h00 && prdata[25:24] == 2'h0
        && prdata[20] && prdata[17:16] == 2'h3;
  endproperty
  a_const_read: assert property (p_const_read) // RULE19 RULE23 RULE25
    else $error("root port capabilities 2 constant wrong");

  // Power management control keeps data select and scale at zero
  property p_pmcs_fixed;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_PM_CTL_STAT
      |-> prdata[14:9] == 6'h00 && prdata[3];
  endproperty
  a_pmcs_fixed: assert property (p_pmcs_fixed) // RULE5
    else $error("data select or data scale not zero");

  // Device types of both capability images, slot bit of the root port image
  property p_exp_caps;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_RP_EXP_CAPS
      |-> prdata[7:4] == 4'h4 && !prdata[8];
  endproperty
  a_exp_caps: assert property (p_exp_caps) // RULE10
    else $error("root port type or slot bit wrong");

  property p_ep_exp_caps;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_EP_EXP_CAPS
      |-> prdata[7:4] == 4'h0;
  endproperty
  a_ep_exp_caps: assert property (p_ep_exp_caps) // RULE10
    else $error("endpoint device type wrong");

  // Shared device capabilities: fixed ones, zeros and payload size
  property p_dev_caps;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_DEV_CAPS
      |-> prdata[15] && prdata[5] && prdata[4:3] == 2'h0
        && prdata[11:6] == 6'h00 && prdata[27:18] == 10'h000
        && prdata[2:0] == MAX_PAYLOAD_CAP;
  endproperty
  a_dev_caps: assert property (p_dev_caps) // RULE11 RULE12 RULE13
    else $error("device capabilities field wrong");

  property p_ep_dctl;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_EP_DEV_CTL
      |-> prdata[10:9] == 2'h0 && !prdata[IPC_DCTL_FLR_BIT];
  endproperty
  a_ep_dctl: assert property (p_ep_dctl) // RULE14
    else $error("endpoint phantom or aux power enable set");

  property p_ep_caps2;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_EP_DEV_CAPS2
      |-> prdata[17] && prdata[20] && prdata[26:24] == 3'h0;
  endproperty
  a_ep_caps2: assert property (p_ep_caps2) // RULE23 RULE24
    else $error("endpoint capabilities 2 constant wrong");

  // Root port advertises exactly what the endpoint needs
  property p_caps2_mirror;
    @(posedge core_clk) disable iff (!rst_n)
    rd_done && paddr == IPC_OFF_RP_DEV_CAPS2
      |-> prdata[5] == EP_NEEDS_ARI && prdata[6] == EP_PEER_ATOMICS
        && prdata[8:7] == {2{EP_ATOMIC_32_64}}
        && prdata[9] == EP_ATOMIC_CAS128 && prdata[31] == EP_FRS_MSGS
        && prdata[11] == EP_LTR_SUP && prdata[19:18] == EP_OBFF_SUP
        && prdata[21] == EP_E2E_PREFIX_SUP
        && prdata[23:22] == EP_E2E_PREFIX_MAX;
  endproperty
  a_caps2_mirror: assert property (p_caps2_mirror) // RULE20 RULE21 RULE22
    else $error("root port capabilities 2 do not mirror endpoint");

  property p_ns_follow;
    @(posedge core_clk) disable iff (!rst_n)
    wr_en && paddr == IPC_OFF_EP_DEV_CTL && pstrb[1]
      |=> ##1 ep_no_snoop_en
        == $past(pwdata[IPC_DCTL_NS_BIT], 2);
  endproperty
  a_ns_follow: assert property (p_ns_follow) // RULE17
    else $error("no snoop enable not followed");

  property p_dllsc_clear;
    @(posedge core_clk) disable iff (!rst_n)
    wr_en && paddr == IPC_OFF_SLOT_CTL_STAT && pstrb[3]
      && pwdata[IPC_SLOT_DLLSC_BIT] && !dll_state_changed
      |=> !slot_reg[IPC_SLOT_DLLSC_BIT];
  endproperty
  a_dllsc_clear: assert property (p_dllsc_clear) // RULE9
    else $error("link state change flag not cleared");

  property p_flr_source;
    @(posedge core_clk) disable iff (!rst_n)
    ep_flr_pulse |-> $past(wr_en)
      && $past(paddr) == IPC_OFF_EP_DEV_CTL;
  endproperty
  a_flr_source: assert property (p_flr_source) // RULE18
    else $error("function reset pulse without endpoint write");

  property p_hot_release;
    @(posedge core_clk) disable iff (!rst_n)
    wr_en && paddr == IPC_OFF_RP_BRIDGE_CTL && pstrb[0]
      && !pwdata[IPC_BRG_SBR_BIT] |=> ##1 !ep_hot_reset;
  endproperty
  a_hot_release: assert property (p_hot_release) // RULE2
    else $error("hot reset held after bus reset cleared");

endmodule // ipc_config_regs

// File: rtl/ipc_pkg.sv
// Function
// RULE1 - Hardware-ignored fields never change block behaviour
// RULE2 - Secondary bus reset hot-resets integrated endpoint
// RULE3 - No endpoint memory requests while bus master off
// RULE4 - Power management aux current reads zero
// RULE5 - Data select and data scale read zero
// RULE6 - Power management data register unimplemented, reads zero
// RULE7 - Slot capabilities read all zero
// RULE8 - Slot control: only link state enable works
// RULE9 - Slot status: link change and presence only
// RULE10 - Fixed device types, root port slot bit zero
// RULE11 - Role based errors and extended tag read one
// RULE12 - Latency and slot power fields read zero
// RULE13 - Same max payload capability in both functions
// RULE14 - Phantom and aux power enable read zero
// RULE15 - Read size, payload, extended tag enable ignored
// RULE16 - Relaxed ordering enable governs endpoint marking only
// RULE17 - No snoop enable governs endpoint, port ignores
// RULE18 - Root port function reset bit reads zero
// RULE19 - Root port completion timeout support reads zero
// RULE20 - Advertise ARI, atomic routing, FRS per endpoint
// RULE21 - Advertise atomic completers per endpoint needs
// RULE22 - Root port mirrors endpoint LTR, OBFF, prefix fields
// RULE23 - 10-bit tag and extended format read one
// RULE24 - Emergency power reduction bits read zero
// RULE25 - Writes to hardwired fields change nothing
package ipc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] IPC_OFF_RP_COMMAND = 8'h00;
  localparam logic [7:0] IPC_OFF_RP_BRIDGE_CTL = 8'h04;
  localparam logic [7:0] IPC_OFF_PM_CAPS = 8'h08;
  localparam logic [7:0] IPC_OFF_PM_CTL_STAT = 8'h0C;
  localparam logic [7:0] IPC_OFF_PM_DATA = 8'h10;
  localparam logic [7:0] IPC_OFF_SLOT_CAPS = 8'h14;
  localparam logic [7:0] IPC_OFF_SLOT_CTL_STAT = 8'h18;
  localparam logic [7:0] IPC_OFF_RP_EXP_CAPS = 8'h1C;
  localparam logic [7:0] IPC_OFF_EP_EXP_CAPS = 8'h20;
  localparam logic [7:0] IPC_OFF_DEV_CAPS = 8'h24;
  localparam logic [7:0] IPC_OFF_RP_DEV_CTL = 8'h28;
  localparam logic [7:0] IPC_OFF_EP_DEV_CTL = 8'h2C;
  localparam logic [7:0] IPC_OFF_RP_DEV_CAPS2 = 8'h30;
  localparam logic [7:0] IPC_OFF_EP_DEV_CAPS2 = 8'h34;
  // Field positions
  localparam int IPC_CMD_BUS_MASTER_BIT = 2;
  localparam int IPC_BRG_SBR_BIT = 6;
  localparam int IPC_SLOT_DLLSC_EN_BIT = 12;
  localparam int IPC_SLOT_PDS_BIT = 22;
  localparam int IPC_SLOT_DLLSC_BIT = 24;
  localparam int IPC_DCTL_RO_BIT = 4;
  localparam int IPC_DCTL_NS_BIT = 11;
  localparam int IPC_DCTL_FLR_BIT = 15;
  // Writable masks of the control registers
  localparam logic [31:0] IPC_DCTL_RP_MASK = 32'h0000_79FF;
  localparam logic [31:0] IPC_DCTL_EP_MASK = 32'h0000_79FF;
  localparam logic [31:0] IPC_PMCS_MASK = 32'h0000_0003;
  // Constant values
  localparam logic [31:0] IPC_PM_CAPS_VAL = 32'h0000_0003;
  localparam logic [31:0] IPC_PMCS_CONST = 32'h0000_0008;
  localparam logic [31:0] IPC_RP_EXP_CAPS_VAL = 32'h0000_0042;
  localparam logic [31:0] IPC_EP_EXP_CAPS_VAL = 32'h0000_0002;
  localparam logic [31:0] IPC_DEV_CAPS_FIXED = 32'h0000_8020;
  localparam logic [31:0] IPC_DEV_CAPS2_FIXED = 32'h0013_0000;
  localparam logic [31:0] IPC_RESET_VAL = 32'h0000_0000;
endpackage

// File: tb/ipc_ep_model.sv
`timescale 1ns/1ps
// Endpoint-side stand-in: requests, link events, presence, reset count
module ipc_ep_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic want_req,
  input wire logic link_evt,
  input wire logic present,
  input wire logic ep_hot_reset,
  input wire logic ep_flr_pulse,
  output logic ep_mem_req_in,
  output logic dll_state_changed,
  output logic presence_detect,
  output logic [7:0] flr_seen
);
  // No requests while the endpoint is held in hot reset
  assign ep_mem_req_in = want_req & ~ep_hot_reset;
  // Link events and presence launched on the clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dll_state_changed <= 1'b0;
      presence_detect <= 1'b0;
      flr_seen <= 8'h00;
    end else begin
      dll_state_changed <= link_evt;
      presence_detect <= present;
      flr_seen <= flr_seen + {7'h00, ep_flr_pulse};
    end
  end
endmodule // ipc_ep_model

// File: tb/integrated_port_config_fields_tb.sv
`timescale 1ns/1ps
module integrated_port_config_fields_tb;
  import ipc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, dll_state_changed, presence_detect;
  logic ep_mem_req_in, ep_mem_req_out, ep_hot_reset;
  logic ep_relaxed_order_en, ep_no_snoop_en, ep_flr_pulse;
  logic want_req = 1'b0;
  logic link_evt = 1'b0;
  logic present = 1'b0;
  logic [7:0] flr_seen;
  logic [31:0] rdat;
  logic rerr;
  int mismatches = 0;
  int checks_done = 0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // Endpoint needs: ARI, 128-bit CAS, LTR, OBFF, two prefixes
  ipc_config_regs #(
    .MAX_PAYLOAD_CAP(3'h2), .EP_NEEDS_ARI(1'b1), .EP_ATOMIC_CAS128(1'b1),
    .EP_LTR_SUP(1'b1), .EP_OBFF_SUP(2'h1), .EP_E2E_PREFIX_SUP(1'b1),
    .EP_E2E_PREFIX_MAX(2'h2)
  ) ipc_config_regs_i (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .dll_state_changed, .presence_detect,
    .ep_mem_req_in, .ep_mem_req_out, .ep_hot_reset, .ep_relaxed_order_en,
    .ep_no_snoop_en, .ep_flr_pulse
  );

  ipc_ep_model ipc_ep_model_i (
    .core_clk, .rst_n, .want_req, .link_evt, .present, .ep_hot_reset,
    .ep_flr_pulse, .ep_mem_req_in, .dll_state_changed, .presence_detect,
    .flr_seen
  );

  // Compare one value and count the outcome
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) mismatches++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Expected read-back after reset (one=0) or after all-ones write
  function automatic logic [31:0] ev(input logic [7:0] a, input logic one);
    logic [31:0] m;
    m = {32{one}};
    case (a)
      IPC_OFF_RP_COMMAND: ev = m & 32'h0000_0004;
      IPC_OFF_RP_BRIDGE_CTL: ev = m & 32'h0000_0040;
      IPC_OFF_PM_CAPS: ev = IPC_PM_CAPS_VAL;
      IPC_OFF_PM_CTL_STAT: ev = IPC_PMCS_CONST | (m & IPC_PMCS_MASK);
      IPC_OFF_SLOT_CTL_STAT: ev = m & 32'h0000_1000;
      IPC_OFF_RP_EXP_CAPS: ev = IPC_RP_EXP_CAPS_VAL;
      IPC_OFF_EP_EXP_CAPS: ev = IPC_EP_EXP_CAPS_VAL;
      IPC_OFF_DEV_CAPS: ev = IPC_DEV_CAPS_FIXED | 32'h0000_0002;
      IPC_OFF_RP_DEV_CTL: ev = m & IPC_DCTL_RP_MASK;
      IPC_OFF_EP_DEV_CTL: ev = m & IPC_DCTL_EP_MASK & 32'h0000_7FFF;
      IPC_OFF_RP_DEV_CAPS2: ev = IPC_DEV_CAPS2_FIXED | 32'h00A4_0A20;
      IPC_OFF_EP_DEV_CAPS2: ev = IPC_DEV_CAPS2_FIXED | 32'h00A4_0800;
      default: ev = 32'h0000_0000;
    endcase
  endfunction

  task automatic complete_run;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values of the whole map
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000, 4'hF);
      chk(rdat, ev(8'(i * 4), 1'b0));
    end
    // Root port capabilities 2 mirror the endpoint's needs
    apb(1'b0, IPC_OFF_RP_DEV_CAPS2, 32'h0000_0000, 4'hF);
    chk(rdat & 32'h00EC_0800, 32'h00A4_0800);
    chk(rdat & 32'h8000_03E0, 32'h0000_0220);
    // All-ones writes: constants hold, controls take effect
    for (int i = 0; i < 14; i++) apb(1'b1, 8'(i * 4), 32'hFFFF_FFFF, 4'hF);
    idle(3);
    chk(32'({ep_hot_reset, ep_relaxed_order_en, ep_no_snoop_en}), 32'h7);
    chk(32'(flr_seen), 32'h0000_0001);
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000, 4'hF);
      chk(rdat, ev(8'(i * 4), 1'b1));
    end
    // Zero writes bring everything back
    for (int i = 0; i < 14; i++) begin
      apb(1'b1, 8'(i * 4), 32'h0000_0000, 4'hF);
      apb(1'b0, 8'(i * 4), 32'h0000_0000, 4'hF);
      chk(rdat, ev(8'(i * 4), 1'b0));
    end
    chk(32'({ep_hot_reset, ep_relaxed_order_en, ep_no_snoop_en}), 32'h0);
    // Bus master gating of endpoint requests
    want_req <= 1'b1;
    idle(4);
    chk(32'(ep_mem_req_out), 32'h0000_0000);
    apb(1'b1, IPC_OFF_RP_COMMAND, 32'h0000_0004, 4'hF);
    idle(3);
    chk(32'(ep_mem_req_out), 32'h0000_0001);
    apb(1'b1, IPC_OFF_RP_COMMAND, 32'h0000_0000, 4'hF);
    idle(3);
    chk(32'(ep_mem_req_out), 32'h0000_0000);
    want_req <= 1'b0;
    // Port ordering bits and ignored fields drive nothing
    apb(1'b1, IPC_OFF_RP_DEV_CTL, 32'h0000_0810, 4'hF);
    apb(1'b1, IPC_OFF_EP_DEV_CTL, 32'h0000_71E0, 4'hF);
    idle(3);
    chk(32'({ep_relaxed_order_en, ep_no_snoop_en}), 32'h0);
    apb(1'b0, IPC_OFF_RP_DEV_CTL, 32'h0000_0000, 4'hF);
    chk(rdat, 32'h0000_0810);
    apb(1'b0, IPC_OFF_EP_DEV_CTL, 32'h0000_0000, 4'hF);
    chk(rdat, 32'h0000_71E0);
    // Byte lane 1 only: no-snoop set, relaxed ordering untouched
    apb(1'b1, IPC_OFF_EP_DEV_CTL, 32'h0000_0810, 4'h2);
    idle(3);
    chk(32'({ep_relaxed_order_en, ep_no_snoop_en}), 32'h1);
    apb(1'b0, IPC_OFF_EP_DEV_CTL, 32'h0000_0000, 4'hF);
    chk(rdat, 32'h0000_08E0);
    apb(1'b1, IPC_OFF_EP_DEV_CTL, 32'h0000_0010, 4'hF);
    idle(3);
    chk(32'({ep_relaxed_order_en, ep_no_snoop_en}), 32'h2);
    // Slot status: link change sticks, clears by write-one
    link_evt <= 1'b1;
    @(posedge core_clk);
    link_evt <= 1'b0;
    present <= 1'b1;
    idle(3);
    apb(1'b0, IPC_OFF_SLOT_CTL_STAT, 32'h0000_0000, 4'hF);
    chk(rdat, 32'h0140_0000);
    apb(1'b1, IPC_OFF_SLOT_CTL_STAT, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, IPC_OFF_SLOT_CTL_STAT, 32'h0000_0000, 4'hF);
    chk(rdat, 32'h0040_1000);
    // Unmapped address
    apb(1'b0, 8'h38, 32'h0000_0000, 4'hF);
    chk(rdat, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    complete_run();
  end
endmodule // integrated_port_config_fields_tb
